// *** sli_pkg.sv ***
// shared constants and carrier types for the status lamp indicator
package sli_pkg;
   // ----------------------------------------
   // clock and timing
   // ----------------------------------------
   localparam int unsigned CLK_HZ = 250_000_000;
   localparam int unsigned HALF_PERIOD_MS = 500;
   localparam int unsigned HALF_PERIOD_CYC = CLK_HZ / 1000 * HALF_PERIOD_MS;
   localparam int unsigned STRETCH_MS = 50;
   localparam int unsigned STRETCH_CYC = CLK_HZ / 1000 * STRETCH_MS;
   localparam int unsigned CNT_W = 32;

   // ----------------------------------------
   // port counts
   // ----------------------------------------
   localparam int unsigned SER_PORTS = 2;
   localparam int unsigned DSP_PORTS = 2;
   localparam int unsigned DIO_CH = 48;
   localparam int unsigned JMP_W = 6;

   // ----------------------------------------
   // register map (plain port)
   // ----------------------------------------
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STAT = 4'h1;
   localparam logic [3:0] ADDR_DIO_LO = 4'h2;
   localparam logic [3:0] ADDR_DIO_HI = 4'h3;
   localparam int unsigned CTRL_RUN_BIT = 0;
   localparam int unsigned CTRL_EXP_BIT = 1;
   localparam int unsigned CTRL_DSP_EXIT_BIT = 2;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam int unsigned STAT_BOOT_BIT = 0;
   localparam int unsigned STAT_USB_BIT = 1;
   localparam int unsigned STAT_HB_BIT = 2;
   localparam int unsigned STAT_RED_BIT = 3;
   localparam int unsigned STAT_YEL_BIT = 4;
   // enabled edges after release before the synchronised straps are taken
   localparam logic [1:0] STRAP_WAIT = 2'h2;

   // display boot-loader phases
   typedef enum logic [1:0] {
      SLI_DSP_BOOT,
      SLI_DSP_KEYS,
      SLI_DSP_SYNC,
      SLI_DSP_APP
   } sli_dsp_t;

   // per-port activity strobes
   typedef struct packed {
      logic [SER_PORTS-1:0] rx;
      logic [SER_PORTS-1:0] tx;
   } sli_act_t;

   // display lamp set
   typedef struct packed {
      logic red;
      logic yellow;
      logic [DSP_PORTS-1:0] rx;
      logic [DSP_PORTS-1:0] tx;
   } sli_dsp_lamp_t;

   // one pulse-stretch step, restarts on a new pulse
   function automatic logic [CNT_W-1:0] stretch_next(input logic hit,
                                                    input logic [CNT_W-1:0] cnt);
      if (hit) begin
         return CNT_W'(STRETCH_CYC);
      end else if (cnt != '0) begin
         return cnt - CNT_W'(1);
      end
      return cnt;
   endfunction : stretch_next
endpackage : sli_pkg

// *** sli_stretch.sv ***
// activity pulse stretcher for one bank of lamps
`timescale 1ns/10ps
module sli_stretch #(
   parameter int unsigned N = 2
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic [N-1:0] pulse,
   output logic [N-1:0] lamp
);
   logic [sli_pkg::CNT_W-1:0] cnt_q [N];
   logic [sli_pkg::CNT_W-1:0] cnt_d [N];

   // ----------------------------------------
   // next counts
   // ----------------------------------------
   // every packet reloads, so a burst reads as one long blink
   always_comb begin
      for (int i = 0; i < N; i++) begin
         cnt_d[i] = sli_pkg::stretch_next(pulse[i], cnt_q[i]);
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      for (int i = 0; i < N; i++) begin
         if (!rst_n) begin
            cnt_q[i] <= '0;
            lamp[i] <= 1'b0;
         end else if (clkEn) begin
            cnt_q[i] <= cnt_d[i];
            lamp[i] <= (cnt_d[i] != '0);
         end
      end
   end
endmodule : sli_stretch

// *** sli_status_led.sv ***
// status lamp logic for controller, expansion module and display
`timescale 1ns/10ps
module sli_status_led (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clkEn,
   // register port
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   // pins
   input wire logic usbDetect,
   input wire logic [sli_pkg::JMP_W-1:0] addrJumper,
   input wire logic dspKeysHeld,
   input wire logic dspAppInvalid,
   // same-clock event strobes
   input wire sli_pkg::sli_act_t serAct,
   input wire logic [sli_pkg::DSP_PORTS-1:0] dspRxPkt,
   input wire logic [sli_pkg::DSP_PORTS-1:0] dspTxPkt,
   input wire logic [sli_pkg::DIO_CH-1:0] dioActive,
   // lamps
   output logic heartbeatLamp,
   output logic expHeartbeatLamp,
   output logic usbLamp,
   output logic [sli_pkg::SER_PORTS-1:0] rxLamp,
   output logic [sli_pkg::SER_PORTS-1:0] txLamp,
   output logic [sli_pkg::DIO_CH-1:0] dioLamp,
   output sli_pkg::sli_dsp_lamp_t dspLamp,
   output logic bootMode,
   output logic outputsEnable
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   localparam int unsigned SW = sli_pkg::JMP_W + 3;
   logic [SW-1:0] syncA_q;
   logic [SW-1:0] syncB_q;
   logic [SW-1:0] syncA_d;
   logic [SW-1:0] syncB_d;
   logic usbS;
   logic anyJumper;
   logic keysS;
   logic invalidS;

   // first stage feeds only the second stage
   always_comb begin
      syncA_d = {usbDetect, dspKeysHeld, dspAppInvalid, addrJumper};
      syncB_d = syncA_q;
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         syncA_q <= '0;
         syncB_q <= '0;
      end else if (clkEn) begin
         syncA_q <= syncA_d;
         syncB_q <= syncB_d;
      end
   end

   assign usbS = syncB_q[SW-1];
   assign keysS = syncB_q[SW-2];
   assign invalidS = syncB_q[SW-3];
   assign anyJumper = |syncB_q[sli_pkg::JMP_W-1:0];

   // ----------------------------------------
   // power-up strap capture
   // ----------------------------------------
   // straps pass two stages, so sample once the synchroniser has filled
   logic [1:0] strapWait_q;
   logic [1:0] strapWait_d;
   logic strapDone_q;
   logic strapDone_d;
   logic boot_q;
   logic boot_d;
   logic keys_q;
   logic keys_d;

   always_comb begin
      strapWait_d = strapWait_q;
      strapDone_d = strapDone_q;
      boot_d = boot_q;
      keys_d = keys_q;
      if (!strapDone_q) begin
         if (strapWait_q == sli_pkg::STRAP_WAIT) begin
            strapDone_d = 1'b1;
            boot_d = usbS || !anyJumper;
            keys_d = keysS;
         end else begin
            strapWait_d = strapWait_q + 2'h1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         strapWait_q <= 2'h0;
         strapDone_q <= 1'b0;
         boot_q <= 1'b1;
         keys_q <= 1'b0;
      end else if (clkEn) begin
         strapWait_q <= strapWait_d;
         strapDone_q <= strapDone_d;
         boot_q <= boot_d;
         keys_q <= keys_d;
      end
   end

   // ----------------------------------------
   // control register and read port
   // ----------------------------------------
   logic red_q;
   logic yel_q;
   logic [31:0] ctrl_q;
   logic [31:0] ctrl_d;
   logic [31:0] rdata_d;
   logic [31:0] stat;

   always_comb begin
      stat = '0;
      stat[sli_pkg::STAT_BOOT_BIT] = boot_q;
      stat[sli_pkg::STAT_USB_BIT] = usbS;
      stat[sli_pkg::STAT_HB_BIT] = heartbeatLamp;
      stat[sli_pkg::STAT_RED_BIT] = red_q;
      stat[sli_pkg::STAT_YEL_BIT] = yel_q;
   end

   // writes to unmapped addresses are dropped
   always_comb begin
      ctrl_d = ctrl_q;
      if (regWr && regAddr == sli_pkg::ADDR_CTRL) begin
         ctrl_d = regWdata;
      end
      rdata_d = '0;
      if (regRd) begin
         if (regAddr == sli_pkg::ADDR_CTRL) begin
            rdata_d = ctrl_q;
         end else if (regAddr == sli_pkg::ADDR_STAT) begin
            rdata_d = stat;
         end else if (regAddr == sli_pkg::ADDR_DIO_LO) begin
            rdata_d = dioLamp[31:0];
         end else if (regAddr == sli_pkg::ADDR_DIO_HI) begin
            rdata_d = 32'(dioLamp[sli_pkg::DIO_CH-1:32]);
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl_q <= sli_pkg::CTRL_RESET;
         regRdata <= '0;
      end else if (clkEn) begin
         ctrl_q <= ctrl_d;
         regRdata <= rdata_d;
      end
   end

   logic appRun;
   logic expRun;
   logic dspExit;
   // boot mode locks the application out regardless of software
   assign appRun = ctrl_q[sli_pkg::CTRL_RUN_BIT] && !boot_q;
   assign expRun = ctrl_q[sli_pkg::CTRL_EXP_BIT];
   assign dspExit = ctrl_q[sli_pkg::CTRL_DSP_EXIT_BIT];

   // ----------------------------------------
   // half-second blink base
   // ----------------------------------------
   logic [sli_pkg::CNT_W-1:0] tick_q;
   logic [sli_pkg::CNT_W-1:0] tick_d;
   logic blink_q;
   logic blink_d;

   always_comb begin
      tick_d = tick_q + sli_pkg::CNT_W'(1);
      blink_d = blink_q;
      if (tick_q == sli_pkg::CNT_W'(sli_pkg::HALF_PERIOD_CYC - 1)) begin
         tick_d = '0;
         blink_d = !blink_q;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tick_q <= '0;
         blink_q <= 1'b1;
      end else if (clkEn) begin
         tick_q <= tick_d;
         blink_q <= blink_d;
      end
   end

   // ----------------------------------------
   // display boot-loader phase
   // ----------------------------------------
   sli_pkg::sli_dsp_t dsp_q;
   sli_pkg::sli_dsp_t dsp_d;

   always_comb begin
      dsp_d = dsp_q;
      case (dsp_q)
         sli_pkg::SLI_DSP_BOOT: begin
            if (strapDone_q) begin
               if (keys_q) begin
                  dsp_d = sli_pkg::SLI_DSP_KEYS;
               end else if (invalidS) begin
                  dsp_d = sli_pkg::SLI_DSP_SYNC;
               end else if (dspExit) begin
                  dsp_d = sli_pkg::SLI_DSP_APP;
               end
            end
         end
         sli_pkg::SLI_DSP_KEYS, sli_pkg::SLI_DSP_SYNC: begin
            if (dspExit && !invalidS) begin
               dsp_d = sli_pkg::SLI_DSP_APP;
            end
         end
         default: begin
            dsp_d = sli_pkg::SLI_DSP_APP;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         dsp_q <= sli_pkg::SLI_DSP_BOOT;
      end else if (clkEn) begin
         dsp_q <= dsp_d;
      end
   end

   // ----------------------------------------
   // lamp drive registers
   // ----------------------------------------
   logic hb_d;
   logic red_d;
   logic yel_d;

   always_comb begin
      hb_d = 1'b0;
      if (boot_q) begin
         hb_d = 1'b1;
      end else if (appRun) begin
         hb_d = blink_q;
      end
      red_d = 1'b0;
      yel_d = 1'b0;
      case (dsp_q)
         sli_pkg::SLI_DSP_BOOT: begin
            red_d = 1'b1;
            yel_d = 1'b1;
         end
         sli_pkg::SLI_DSP_KEYS: begin
            red_d = blink_q;
         end
         sli_pkg::SLI_DSP_SYNC: begin
            yel_d = blink_q;
         end
         default: begin
            red_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         heartbeatLamp <= 1'b0;
         expHeartbeatLamp <= 1'b0;
         usbLamp <= 1'b0;
         dioLamp <= '0;
         red_q <= 1'b0;
         yel_q <= 1'b0;
         bootMode <= 1'b1;
         outputsEnable <= 1'b0;
      end else if (clkEn) begin
         heartbeatLamp <= hb_d;
         expHeartbeatLamp <= expRun && blink_q;
         usbLamp <= usbS;
         dioLamp <= dioActive;
         red_q <= red_d;
         yel_q <= yel_d;
         bootMode <= boot_q;
         outputsEnable <= appRun;
      end
   end

   // ----------------------------------------
   // activity blinks
   // ----------------------------------------
   // one driver per lamp word; bank order follows the pulse concatenation
   logic [2*sli_pkg::SER_PORTS-1:0] serLamp;
   logic [2*sli_pkg::DSP_PORTS-1:0] dspActLamp;
   assign rxLamp = serLamp[2*sli_pkg::SER_PORTS-1:sli_pkg::SER_PORTS];
   assign txLamp = serLamp[sli_pkg::SER_PORTS-1:0];
   assign dspLamp = {red_q, yel_q, dspActLamp};

   // controller ports
   sli_stretch #(
      .N(2 * sli_pkg::SER_PORTS)
   ) u_serStretch (
      .mclk(mclk),
      .rst_n(rst_n),
      .clkEn(clkEn),
      .pulse({serAct.rx, serAct.tx}),
      .lamp(serLamp)
   );

   // display ports
   sli_stretch #(
      .N(2 * sli_pkg::DSP_PORTS)
   ) u_dspStretch (
      .mclk(mclk),
      .rst_n(rst_n),
      .clkEn(clkEn),
      .pulse({dspRxPkt, dspTxPkt}),
      .lamp(dspActLamp)
   );
endmodule : sli_status_led

// *** sli_status_led_sva.sv ***
// assertion checker for the status lamp block
`timescale 1ns/10ps
module sli_status_led_sva (
   input wire logic mclk,
   input wire logic rst_n,
   input wire sli_pkg::sli_act_t serAct,
   input wire logic [sli_pkg::DSP_PORTS-1:0] dspRxPkt,
   input wire logic [sli_pkg::DSP_PORTS-1:0] dspTxPkt,
   input wire logic [sli_pkg::DIO_CH-1:0] dioActive,
   input wire logic usbDetect,
   input wire logic heartbeatLamp,
   input wire logic usbLamp,
   input wire logic [sli_pkg::SER_PORTS-1:0] rxLamp,
   input wire logic [sli_pkg::SER_PORTS-1:0] txLamp,
   input wire logic [sli_pkg::DIO_CH-1:0] dioLamp,
   input wire sli_pkg::sli_dsp_lamp_t dspLamp,
   input wire logic bootMode,
   input wire logic outputsEnable
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   // ----------------------------------------
   // steps
   // ----------------------------------------
   // margin covers the pin synchroniser ahead of the lamp
   sequence bootHeld;
      bootMode [*3];
   endsequence
   sequence usbSteady;
      $stable(usbDetect) [*5];
   endsequence
   sequence dioSteady;
      $stable(dioActive) [*2];
   endsequence

   // ----------------------------------------
   // lamp relations
   // ----------------------------------------
   boot_lamp_a: assert property (bootHeld |-> heartbeatLamp)
      else $error("heartbeat lamp dark in boot mode");
   out_off_a: assert property (bootMode |-> !outputsEnable)
      else $error("outputs enabled in boot mode");
   usb_follow_a: assert property (usbSteady |-> usbLamp == usbDetect)
      else $error("usb lamp does not follow cable");
   dio_follow_a: assert property (dioSteady |-> dioLamp == dioActive)
      else $error("channel lamp does not follow signal");
   ser_rx_a: assert property (|serAct.rx |=> (rxLamp & $past(serAct.rx)) == $past(serAct.rx))
      else $error("receive lamp missed a packet");
   ser_tx_a: assert property (|serAct.tx |=> (txLamp & $past(serAct.tx)) == $past(serAct.tx))
      else $error("transmit lamp missed a packet");
   dsp_act_a: assert property (|{dspRxPkt, dspTxPkt} |=>
      ({dspLamp.rx, dspLamp.tx} & $past({dspRxPkt, dspTxPkt})) == $past({dspRxPkt, dspTxPkt}))
      else $error("display activity lamp missed a packet");
   keys_yellow_a: assert property (dspLamp.red && !dspLamp.yellow |=> !dspLamp.yellow)
      else $error("yellow lit during key boot");
   sync_red_a: assert property (!dspLamp.red && dspLamp.yellow |=> !dspLamp.red)
      else $error("red lit during resync");
   dsp_entry_a: assert property ($rose(rst_n) |-> ##[0:6] (dspLamp.red && dspLamp.yellow))
      else $error("display boot lamps not both lit");
endmodule : sli_status_led_sva

bind sli_status_led sli_status_led_sva chk (
   .mclk(mclk), .rst_n(rst_n), .serAct(serAct), .dspRxPkt(dspRxPkt),
   .dspTxPkt(dspTxPkt), .dioActive(dioActive), .usbDetect(usbDetect),
   .heartbeatLamp(heartbeatLamp), .usbLamp(usbLamp), .rxLamp(rxLamp),
   .txLamp(txLamp), .dioLamp(dioLamp), .dspLamp(dspLamp), .bootMode(bootMode),
   .outputsEnable(outputsEnable)
);

// *** sli_lamp_view.sv ***
// operator view of the activity lamps, counting visible blinks
`timescale 1ns/10ps
module sli_lamp_view (
   input wire logic mclk,
   input wire logic [1:0] rxLamp,
   input wire logic [1:0] txLamp,
   output int rxBlinks = 0,
   output int txBlinks = 0
);
   logic [1:0] rxOld = '0;
   logic [1:0] txOld = '0;

   // a blink is a dark-to-lit edge; a retriggered lamp counts once
   always @(posedge mclk) begin
      rxBlinks <= rxBlinks + $countones(rxLamp & ~rxOld);
      txBlinks <= txBlinks + $countones(txLamp & ~txOld);
      rxOld <= rxLamp;
      txOld <= txLamp;
   end
endmodule : sli_lamp_view

// *** test_sli_status_led.sv ***
// self-checking bench for the status lamp block
`timescale 1ns/10ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; \
   $display("ERROR %0t: got %h exp %h", $time, got, exp); end end
module test_sli_status_led;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] regAddr = '0;
   logic [31:0] regWdata = '0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [31:0] regRdata;
   logic usbDetect = 1'b0;
   logic [5:0] addrJumper = 6'h01;
   logic dspKeysHeld = 1'b0;
   logic dspAppInvalid = 1'b0;
   sli_pkg::sli_act_t serAct = '0;
   logic [1:0] dspRxPkt = '0;
   logic [1:0] dspTxPkt = '0;
   logic [47:0] dioActive = '0;
   logic heartbeatLamp, expHeartbeatLamp, usbLamp, bootMode, outputsEnable;
   logic [1:0] rxLamp, txLamp;
   logic [47:0] dioLamp;
   sli_pkg::sli_dsp_lamp_t dspLamp;
   int error_cnt = 0;
   int cmp_count = 0;
   int rxBlinks, txBlinks;
   logic rdPend = 1'b0;
   logic [31:0] expRd;
   logic [31:0] expQ[$];

   always #2 mclk = ~mclk;

   sli_status_led dut (
      .mclk(mclk), .rst_n(rst_n), .clkEn(1'b1), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .usbDetect(usbDetect),
      .addrJumper(addrJumper), .dspKeysHeld(dspKeysHeld), .dspAppInvalid(dspAppInvalid),
      .serAct(serAct), .dspRxPkt(dspRxPkt), .dspTxPkt(dspTxPkt), .dioActive(dioActive),
      .heartbeatLamp(heartbeatLamp), .expHeartbeatLamp(expHeartbeatLamp),
      .usbLamp(usbLamp), .rxLamp(rxLamp), .txLamp(txLamp), .dioLamp(dioLamp),
      .dspLamp(dspLamp), .bootMode(bootMode), .outputsEnable(outputsEnable)
   );
   sli_lamp_view view (
      .mclk(mclk), .rxLamp(rxLamp), .txLamp(txLamp), .rxBlinks(rxBlinks), .txBlinks(txBlinks)
   );

   // ----------------------------------------
   // bus and power-up tasks
   // ----------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask : tick
   // a spare cycle after each strobe keeps one assignment per time step
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      tick(1);
      regWr <= 1'b0;
      tick(1);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      expQ.push_back(e);
      regAddr <= a;
      regRd <= 1'b1;
      tick(1);
      regRd <= 1'b0;
      tick(1);
   endtask : rd
   // straps count only when sampled after a reset
   task automatic power_up(input logic usb, input logic [5:0] jmp, input logic keys,
                           input logic inv);
      rst_n <= 1'b0;
      usbDetect <= usb;
      addrJumper <= jmp;
      dspKeysHeld <= keys;
      dspAppInvalid <= inv;
      tick(6);
      rst_n <= 1'b1;
      tick(12);
   endtask : power_up
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : conclude

   // read data stands only in the cycle after the strobe
   always @(posedge mclk) begin
      if (rdPend) begin
         expRd = expQ.pop_front();
         `CHK(regRdata, expRd)
      end
      rdPend <= regRd;
   end

   // watchdog, far beyond the roughly 175 cycles of the run
   initial begin
      #20000;
      error_cnt++;
      conclude();
   end

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      void'($urandom(32'h2314));
      power_up(1'b0, 6'h01, 1'b0, 1'b0);
      `CHK(bootMode, 1'b0)
      `CHK({dspLamp.red, dspLamp.yellow}, 2'b11)
      `CHK({heartbeatLamp, expHeartbeatLamp}, 2'b00)
      rd(sli_pkg::ADDR_STAT, 32'h0000_0018);
      rd(sli_pkg::ADDR_CTRL, sli_pkg::CTRL_RESET);
      rd(4'hf, 32'h0000_0000);
      wr(sli_pkg::ADDR_CTRL, 32'h0000_0007);
      rd(sli_pkg::ADDR_CTRL, 32'h0000_0007);
      tick(4);
      `CHK({dspLamp.red, dspLamp.yellow}, 2'b00)
      `CHK(expHeartbeatLamp, heartbeatLamp)
      serAct <= 4'hf;
      dspRxPkt <= 2'b11;
      dspTxPkt <= 2'b11;
      tick(1);
      dspRxPkt <= 2'b00;
      dspTxPkt <= 2'b00;
      for (int i = 0; i < 20; i++) begin
         serAct <= 4'($urandom);
         tick(1);
      end
      serAct <= '0;
      tick(2);
      `CHK(rxLamp, 2'b11)
      `CHK(txLamp, 2'b11)
      `CHK({dspLamp.rx, dspLamp.tx}, 4'hf)
      `CHK(rxBlinks, 2)
      `CHK(txBlinks, 2)
      for (int i = 0; i < 8; i++) begin
         dioActive <= 48'({$urandom, $urandom});
         tick(3);
         `CHK(dioLamp, dioActive)
      end
      rd(sli_pkg::ADDR_DIO_LO, dioActive[31:0]);
      rd(sli_pkg::ADDR_DIO_HI, 32'(dioActive[47:32]));
      usbDetect <= 1'b1;
      tick(6);
      `CHK(usbLamp, 1'b1)
      usbDetect <= 1'b0;
      tick(6);
      `CHK(usbLamp, 1'b0)
      power_up(1'b0, 6'h00, 1'b0, 1'b0);
      `CHK({bootMode, outputsEnable, heartbeatLamp}, 3'b101)
      power_up(1'b1, 6'h3f, 1'b0, 1'b0);
      `CHK(bootMode, 1'b1)
      power_up(1'b0, 6'h01, 1'b1, 1'b0);
      `CHK(dspLamp.yellow, 1'b0)
      power_up(1'b0, 6'h01, 1'b0, 1'b1);
      `CHK(dspLamp.red, 1'b0)
      dspAppInvalid <= 1'b0;
      wr(sli_pkg::ADDR_CTRL, 32'h0000_0004);
      tick(6);
      `CHK({dspLamp.red, dspLamp.yellow}, 2'b00)
      conclude();
   end
endmodule : test_sli_status_led
